// ### hdl/display_select.sv
`timescale 1ns/1ns
`include "motor_thermal_consts.svh"
module display_select #(
    parameter int NUM_SCREENS = `NUM_SCREENS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Keys
    input wire logic key_up,
    input wire logic key_down,
    // Screen
    output logic [2:0] screen
);
    localparam logic [2:0] LAST = 3'(NUM_SCREENS - 1);

    ovl_pkg::disp_state_t q;
    ovl_pkg::disp_state_t n;

    // Both directions wrap at the ends
    always_comb begin
        n = q;
        if (key_up && !key_down) begin
            n.screen = (q.screen == LAST) ? 3'h0 : q.screen + 3'h1;
        end else if (key_down && !key_up) begin
            n.screen = (q.screen == 3'h0) ? LAST : q.screen - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.screen <= 3'h0;
        end else begin
            q <= n;
        end
    end

    assign screen = q.screen;

    sequence s_four_up;
        (key_up && !key_down)[*4];
    endsequence
    property p_four_up;
        @(posedge clk) disable iff (!rst_n)
        (screen == 3'h0) ##0 s_four_up |=> screen == `HEAT_SCREEN;
    endproperty
    a_four_up: assert property (p_four_up) else $error("four up presses miss heat screen");
    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        screen == 3'h0 && key_down && !key_up |=> screen == LAST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("down key does not wrap");
endmodule : display_select

// ### hdl/motor_thermal_consts.svh
`ifndef MOTOR_THERMAL_CONSTS_SVH
`define MOTOR_THERMAL_CONSTS_SVH

// Timing
`define CLK_KHZ 50000
`define TICK_MS 10
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define FLASH_MS 500
`define FLASH_TICKS (`FLASH_MS / `TICK_MS)

// Thermal scaling
`define PCT_FULL 7'h64
`define TRIP_RATIO_SQ 48'h24
`define SF_SCALE_SQ 48'h2710
`define DIV3_MUL 20'h2ab
`define DIV3_SHIFT 11

// Reset values
`define FLA_RESET 16'h0000
`define SF_RESET 8'h64
`define CLASS_RESET 5'h0a

// Register offsets
`define OFS_FLA 8'h00
`define OFS_SF 8'h04
`define OFS_SCLS 8'h08
`define OFS_RCLS 8'h0c
`define OFS_MODE 8'h10
`define OFS_STATUS 8'h14
`define OFS_HEAT 8'h18
`define OFS_RESTART 8'h1c

// Status field positions
`define STAT_TRIP 0
`define STAT_COOLED 1
`define STAT_INHIBIT 2
`define STAT_LED 3
`define STAT_STATE 4
`define STAT_FAULT 9

// Display and storage
`define NUM_SCREENS 6
`define HEAT_SCREEN 3'h4
`define NVM_PCT_ADDR 2'h0

`endif

// ### hdl/motor_thermal_overload.sv
`timescale 1ns/1ns
`include "motor_thermal_consts.svh"
module motor_thermal_overload #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Motor and start control
    input wire logic [15:0] motor_current,
    input wire logic at_speed,
    input wire logic start_req,
    input wire logic stop_req,
    output logic run_cmd,
    output logic overload_trip,
    // Keypad and display
    input wire logic reset_key,
    input wire logic key_up,
    input wire logic key_down,
    output logic overload_led,
    output logic [2:0] screen_index,
    output logic heat_screen,
    output logic [6:0] remaining_heat_readout,
    output ovl_pkg::fault_code_t fault_code,
    // Storage
    input wire logic nvm_format
);
    ovl_pkg::thermal_state_t q;
    ovl_pkg::thermal_state_t n;

    logic tick, heating, cooled, press, rise;
    logic [15:0] fla;
    logic [4:0] cls;
    logic [31:0] fla_sq, cur_sq;
    logic [23:0] fsf;
    logic [47:0] unit, fsum;
    logic [8:0] hsum;
    logic [19:0] sum_mul;
    logic [6:0] restart_capacity_threshold, used;
    logic nvm_we;
    logic [1:0] nvm_waddr;
    logic [6:0] nvm_wdata, nvm_rdata;

    assign fla = q.motor_full_load_current_setting;
    assign tick = q.tick_cnt == 20'(TICK_CYCLES - 1);
    assign cls = at_speed ? q.run_trip_class_setting : q.start_trip_class_setting;
    assign fla_sq = 32'(fla) * 32'(fla);
    assign cur_sq = 32'(motor_current) * 32'(motor_current);
    assign fsf = 24'(fla) * 24'(q.service_factor_setting);
    // One percent of capacity is a hundredth of class seconds at 600 percent
    assign unit = 48'(fla_sq) * 48'(cls) * `TRIP_RATIO_SQ;
    // Heats above full-load times service factor, cools below it
    assign heating = 48'(cur_sq) * `SF_SCALE_SQ > 48'(fsf) * 48'(fsf);
    assign fsum = q.frac + 48'(cur_sq);
    assign hsum = 9'(q.hist[0]) + 9'(q.hist[1]) + 9'(q.hist[2]);
    // Divide by three as multiply and shift; at most one percent low
    assign sum_mul = 20'(hsum) * `DIV3_MUL;
    assign restart_capacity_threshold = sum_mul[`DIV3_SHIFT +: 7];
    assign cooled = q.pct >= restart_capacity_threshold && q.pct != 7'h00;
    assign press = reset_key && !q.key_q;
    assign rise = at_speed && !q.speed_q;
    assign used = (q.start_pct > q.pct) ? q.start_pct - q.pct : 7'h00;

    // History write wins the port; percent write waits one cycle
    assign nvm_we = q.hist_pend || q.pct_dirty;
    assign nvm_waddr = q.hist_pend ? q.hist_waddr : `NVM_PCT_ADDR;
    assign nvm_wdata = q.hist_pend ? q.hist_wval : q.pct;

    thermal_nvm #(
        .DEPTH(4),
        .WIDTH(7)
    ) u_nvm (
        .clk(clk),
        .rst_n(rst_n),
        .format(nvm_format),
        .we(nvm_we),
        .waddr(nvm_waddr),
        .wdata(nvm_wdata),
        .raddr(q.load_cnt[1:0]),
        .rdata(nvm_rdata)
    );

    display_select #(
        .NUM_SCREENS(`NUM_SCREENS)
    ) u_disp (
        .clk(clk),
        .rst_n(rst_n),
        .key_up(key_up),
        .key_down(key_down),
        .screen(screen_index)
    );

    always_comb begin
        n = q;
        n.rdata = 32'h0;
        n.key_q = reset_key;
        n.speed_q = at_speed;
        n.tick_cnt = tick ? 20'h0 : q.tick_cnt + 20'h1;
        if (q.hist_pend) begin
            n.hist_pend = 1'b0;
        end else if (q.pct_dirty) begin
            n.pct_dirty = 1'b0;
        end
        if (reg_write) begin
            case (reg_addr)
                `OFS_FLA: n.motor_full_load_current_setting = reg_wdata[15:0];
                `OFS_SF: n.service_factor_setting = reg_wdata[7:0];
                `OFS_SCLS: n.start_trip_class_setting = reg_wdata[4:0];
                `OFS_RCLS: n.run_trip_class_setting = reg_wdata[4:0];
                `OFS_MODE: n.overload_mode_select = ovl_pkg::ovl_mode_t'(reg_wdata[1:0]);
                default: ;
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                `OFS_FLA: n.rdata = {16'h0, fla};
                `OFS_SF: n.rdata = {24'h0, q.service_factor_setting};
                `OFS_SCLS: n.rdata = {27'h0, q.start_trip_class_setting};
                `OFS_RCLS: n.rdata = {27'h0, q.run_trip_class_setting};
                `OFS_MODE: n.rdata = {30'h0, q.overload_mode_select};
                `OFS_STATUS: begin
                    n.rdata[`STAT_TRIP] = q.trip;
                    n.rdata[`STAT_COOLED] = cooled;
                    n.rdata[`STAT_INHIBIT] = q.inhibit;
                    n.rdata[`STAT_LED] = q.led;
                    n.rdata[`STAT_STATE +: 5] = q.st;
                    n.rdata[`STAT_FAULT +: 4] = q.fault_code;
                end
                `OFS_HEAT: n.rdata = {25'h0, q.pct};
                `OFS_RESTART: n.rdata = {25'h0, restart_capacity_threshold};
                default: n.rdata = 32'h0;
            endcase
        end
        if (tick && fla != 16'h0000 && q.st != ovl_pkg::st_load) begin
            if (heating) begin
                if (fsum >= unit) begin
                    n.frac = fsum - unit;
                    if (q.pct != 7'h00) begin
                        n.pct = q.pct - 7'h01;
                        n.pct_dirty = 1'b1;
                    end
                end else begin
                    n.frac = fsum;
                end
            end else if (q.frac >= 48'(fla_sq)) begin
                n.frac = q.frac - 48'(fla_sq);
            end else if (q.pct < `PCT_FULL) begin
                n.pct = q.pct + 7'h01;
                n.frac = q.frac + unit - 48'(fla_sq);
                n.pct_dirty = 1'b1;
            end else begin
                n.frac = 48'h0;
            end
        end
        if (tick) begin
            if (q.flash_cnt == 8'(`FLASH_TICKS - 1)) begin
                n.flash_cnt = 8'h00;
                n.flash = !q.flash;
            end else begin
                n.flash_cnt = q.flash_cnt + 8'h01;
            end
        end
        case (q.st)
            ovl_pkg::st_load: begin
                n.load_cnt = q.load_cnt + 3'h1;
                case (q.load_cnt)
                    3'h1: n.pct = (nvm_rdata > `PCT_FULL) ? `PCT_FULL : nvm_rdata;
                    3'h2: n.hist[0] = nvm_rdata;
                    3'h3: n.hist[1] = nvm_rdata;
                    3'h4: begin
                        n.hist[2] = nvm_rdata;
                        n.st = ovl_pkg::st_ready;
                    end
                    default: ;
                endcase
            end
            ovl_pkg::st_ready: begin
                if (start_req && fla == 16'h0000) begin
                    n.st = ovl_pkg::st_fault;
                    n.fault_code = ovl_pkg::missing_full_load_fault_code;
                end else if (start_req) begin
                    n.st = ovl_pkg::st_run;
                    n.start_pct = q.pct;
                end
            end
            ovl_pkg::st_run: begin
                if (stop_req) begin
                    n.st = ovl_pkg::st_ready;
                end else if (rise) begin
                    n.hist[q.hist_ptr] = used;
                    n.hist_wval = used;
                    n.hist_waddr = q.hist_ptr + 2'h1;
                    n.hist_pend = 1'b1;
                    n.hist_ptr = (q.hist_ptr == 2'h2) ? 2'h0 : q.hist_ptr + 2'h1;
                end
            end
            ovl_pkg::st_trip: begin
                // Start requests are not looked at here
                if (q.overload_mode_select == ovl_pkg::ol_off
                    || (cooled && (q.overload_mode_select == ovl_pkg::ol_auto || press))) begin
                    n.st = ovl_pkg::st_ready;
                    n.trip = 1'b0;
                    n.inhibit = 1'b0;
                end else if (press) begin
                    n.inhibit = 1'b1;
                end
            end
            ovl_pkg::st_fault: begin
                if (press && fla != 16'h0000) begin
                    n.st = ovl_pkg::st_ready;
                    n.fault_code = ovl_pkg::fc_none;
                end
            end
            default: n.st = ovl_pkg::st_load;
        endcase
        // Trip decided after everything else; the reset key has no say here
        if ((q.st == ovl_pkg::st_run || q.st == ovl_pkg::st_ready) && q.pct == 7'h00
            && q.overload_mode_select != ovl_pkg::ol_off) begin
            n.st = ovl_pkg::st_trip;
            n.trip = 1'b1;
        end
        n.led = n.trip && (!cooled || n.flash);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ovl_pkg::st_load;
            q.motor_full_load_current_setting <= `FLA_RESET;
            q.service_factor_setting <= `SF_RESET;
            q.start_trip_class_setting <= `CLASS_RESET;
            q.run_trip_class_setting <= `CLASS_RESET;
            q.overload_mode_select <= ovl_pkg::ol_manual;
            q.pct <= `PCT_FULL;
            q.fault_code <= ovl_pkg::fc_none;
        end else begin
            q <= n;
        end
    end

    assign run_cmd = q.st == ovl_pkg::st_run;
    assign overload_trip = q.trip;
    assign overload_led = q.led;
    assign remaining_heat_readout = q.pct;
    assign heat_screen = screen_index == `HEAT_SCREEN;
    assign fault_code = q.fault_code;
    assign reg_rdata = q.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_zero_start;
        q.st == ovl_pkg::st_ready && start_req && fla == 16'h0000;
    endsequence
    property p_no_fla_start;
        s_zero_start |=> q.st == ovl_pkg::st_fault
            && fault_code == ovl_pkg::missing_full_load_fault_code;
    endproperty
    a_no_fla_start: assert property (p_no_fla_start) else $error("no fault on zero current");
    property p_zero_never_runs;
        fla == 16'h0000 && q.st != ovl_pkg::st_run |=> !run_cmd;
    endproperty
    a_zero_never_runs: assert property (p_zero_never_runs) else $error("ran with zero current");
    property p_trip_on_zero;
        q.st == ovl_pkg::st_run && q.pct == 7'h00
            && q.overload_mode_select != ovl_pkg::ol_off |=> overload_trip && !run_cmd;
    endproperty
    a_trip_on_zero: assert property (p_trip_on_zero) else $error("no trip at zero capacity");
    property p_trip_free;
        q.st == ovl_pkg::st_run && q.pct == 7'h00 && reset_key
            && q.overload_mode_select != ovl_pkg::ol_off |=> overload_trip;
    endproperty
    a_trip_free: assert property (p_trip_free) else $error("reset key held off a trip");
    property p_disabled;
        $rose(overload_trip) |-> $past(q.overload_mode_select) != ovl_pkg::ol_off;
    endproperty
    a_disabled: assert property (p_disabled) else $error("trip while protection off");
    property p_led_steady;
        $past(overload_trip) && $past(!cooled) && overload_trip |-> overload_led;
    endproperty
    a_led_steady: assert property (p_led_steady) else $error("led not steady before cooling");
    property p_led_flash;
        $past(overload_trip) && $past(cooled) && overload_trip |-> overload_led == q.flash;
    endproperty
    a_led_flash: assert property (p_led_flash) else $error("led not flashing after cooling");
    sequence s_manual_wait;
        q.st == ovl_pkg::st_trip && q.overload_mode_select == ovl_pkg::ol_manual && !press;
    endsequence
    property p_manual_hold;
        s_manual_wait |=> q.st == ovl_pkg::st_trip && !run_cmd;
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("left trip without reset");
    property p_reset_ignored;
        q.st == ovl_pkg::st_trip && !cooled
            && q.overload_mode_select != ovl_pkg::ol_off |=> overload_trip;
    endproperty
    a_reset_ignored: assert property (p_reset_ignored) else $error("trip reset while hot");
    property p_auto_clear;
        q.st == ovl_pkg::st_trip && cooled && q.overload_mode_select == ovl_pkg::ol_auto
            |=> !overload_trip && q.st == ovl_pkg::st_ready;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto reset did not clear");
    property p_pct_range;
        q.pct <= `PCT_FULL;
    endproperty
    a_pct_range: assert property (p_pct_range) else $error("capacity above full");
    property p_heat_drop;
        q.pct < $past(q.pct) && $past(q.st) != ovl_pkg::st_load |-> $past(heating && tick);
    endproperty
    a_heat_drop: assert property (p_heat_drop) else $error("capacity fell without heating");
    property p_cool_rise;
        q.pct > $past(q.pct) && $past(q.st) != ovl_pkg::st_load |-> $past(!heating && tick);
    endproperty
    a_cool_rise: assert property (p_cool_rise) else $error("capacity rose while heating");
    sequence s_speed_up;
        q.st == ovl_pkg::st_run && rise && !stop_req;
    endsequence
    sequence s_hist_store;
        ##1 (nvm_we && nvm_waddr != `NVM_PCT_ADDR && nvm_wdata == $past(used));
    endsequence
    property p_hist;
        s_speed_up |-> s_hist_store;
    endproperty
    a_hist: assert property (p_hist) else $error("start history not stored");
    property p_persist;
        q.pct != $past(q.pct) && $past(q.st) != ovl_pkg::st_load
            |-> ##[0:2] (nvm_we && nvm_waddr == `NVM_PCT_ADDR);
    endproperty
    a_persist: assert property (p_persist) else $error("capacity not written back");
endmodule : motor_thermal_overload

// ### hdl/ovl_pkg.sv
package ovl_pkg;
    typedef enum logic [4:0] {
        st_load = 5'h01,
        st_ready = 5'h02,
        st_run = 5'h04,
        st_trip = 5'h08,
        st_fault = 5'h10
    } ovl_state_t;

    typedef enum logic [1:0] {
        ol_manual = 2'h0,
        ol_auto = 2'h1,
        ol_off = 2'h2
    } ovl_mode_t;

    typedef enum logic [3:0] {
        fc_none = 4'h0,
        missing_full_load_fault_code = 4'h1
    } fault_code_t;

    typedef struct packed {
        logic [2:0] screen;
    } disp_state_t;

    typedef struct packed {
        ovl_state_t st;
        logic [15:0] motor_full_load_current_setting;
        logic [7:0] service_factor_setting;
        logic [4:0] start_trip_class_setting;
        logic [4:0] run_trip_class_setting;
        ovl_mode_t overload_mode_select;
        logic [6:0] pct;
        logic [47:0] frac;
        logic [2:0][6:0] hist;
        logic [1:0] hist_ptr;
        logic [1:0] hist_waddr;
        logic [6:0] hist_wval;
        logic hist_pend;
        logic pct_dirty;
        logic [6:0] start_pct;
        logic [2:0] load_cnt;
        logic [19:0] tick_cnt;
        logic [7:0] flash_cnt;
        logic flash;
        logic led;
        logic inhibit;
        logic trip;
        logic key_q;
        logic speed_q;
        fault_code_t fault_code;
        logic [31:0] rdata;
    } thermal_state_t;
endpackage : ovl_pkg

// ### hdl/thermal_nvm.sv
`timescale 1ns/1ns
`include "motor_thermal_consts.svh"
module thermal_nvm #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Factory format
    input wire logic format,
    // Write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } nvm_state_t;

    nvm_state_t q;
    nvm_state_t n;

    // Contents survive rst_n; only we and format rewrite them
    always_comb begin
        n = q;
        n.rdata = q.mem[raddr];
        if (we) begin
            n.mem[waddr] = wdata;
        end
        if (format) begin
            n.mem = '0;
            n.mem[0] = WIDTH'(`PCT_FULL);
        end
        if (!rst_n) begin
            n.rdata = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= n;
    end

    assign rdata = q.rdata;

    property p_nvm_read;
        @(posedge clk) disable iff (!rst_n)
        !format && !we ##1 rst_n |-> rdata == $past(q.mem[raddr]);
    endproperty
    a_nvm_read: assert property (p_nvm_read) else $error("stored value not returned");
endmodule : thermal_nvm

// ### tb/keypad_model.sv
`timescale 1ns/1ns
module keypad_model (
    // Clock
    input wire logic clk,
    // Bench command and device state
    input wire logic [2:0] cmd,
    input wire logic overload_trip,
    // Keys and start line
    output logic key_up = 1'b0,
    output logic key_down = 1'b0,
    output logic reset_key = 1'b0,
    output logic start_req = 1'b0
);
    always @(posedge clk) begin
        key_up <= (cmd == 3'h1);
        key_down <= (cmd == 3'h2);
        reset_key <= (cmd == 3'h4);
        // Three-wire control never starts into a live trip
        start_req <= (cmd == 3'h3) && !overload_trip;
    end
endmodule : keypad_model

// ### tb/motor_thermal_overload_tb.sv
`timescale 1ns/1ns
module motor_thermal_overload_tb;
    // Short tick keeps the cooling waits affordable
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] motor_current = 16'h0000;
    logic at_speed = 1'b0;
    logic [6:0] heat;
    logic nvm_format = 1'b1;
    logic [2:0] cmd = 3'h0;
    logic key_up, key_down, reset_key, start_req, run_cmd, overload_trip, overload_led;
    logic heat_screen;
    logic [2:0] screen_index;
    logic [6:0] remaining_heat_readout;
    ovl_pkg::fault_code_t fault_code;
    logic [31:0] exp_q[$];
    logic rd_q = 1'b0;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 95;
    int i;

    always #10 clk = ~clk;

    motor_thermal_overload #(.TICK_CYCLES(TICK)) u_motor_thermal_overload (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .motor_current(motor_current), .at_speed(at_speed), .start_req(start_req),
        .stop_req(1'b0), .run_cmd(run_cmd), .overload_trip(overload_trip),
        .reset_key(reset_key), .key_up(key_up), .key_down(key_down),
        .overload_led(overload_led), .screen_index(screen_index), .heat_screen(heat_screen),
        .remaining_heat_readout(remaining_heat_readout), .fault_code(fault_code),
        .nvm_format(nvm_format));

    keypad_model u_keypad_model (.clk(clk), .cmd(cmd), .overload_trip(overload_trip),
        .key_up(key_up), .key_down(key_down), .reset_key(reset_key), .start_req(start_req));

    task cmp(input string name, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", name, e, s);
        end
    endtask : cmp

    task complete_run;
        $display("Comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : rd

    task key(input logic [2:0] c, input int n = 1);
        @(posedge clk);
        cmd <= c;
        repeat (n) @(posedge clk);
        cmd <= 3'h0;
    endtask : key

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_q <= reg_read;
    always @(negedge clk) if (rd_q) cmp("reg_rdata", exp_q.pop_front(), reg_rdata);

    always @(posedge clk) begin
        cycles++;
        if (cycles == 99000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        @(posedge clk);
        nvm_format <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        settle(8);
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h18, 32'h64);
        rd(8'h20, 32'h0);
        motor_current <= 16'($random(seed));
        key(3'h3);
        settle(3);
        cmp("fault_code", 32'h1, {28'h0, fault_code});
        cmp("run_cmd", 32'h0, {31'h0, run_cmd});
        key(3'h1, 4);
        settle(2);
        cmp("heat_screen", 32'h1, {31'h0, heat_screen});
        cmp("readout", 32'h64, {25'h0, remaining_heat_readout});
        repeat (2) key(3'h1);
        repeat (2) key(3'h2);
        settle(2);
        cmp("screen_index", 32'h4, {29'h0, screen_index});
        motor_current <= 16'h0;
        wr(8'h08, 32'h1);
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h1);
        key(3'h4);
        key(3'h3);
        settle(2);
        cmp("run_cmd", 32'h1, {31'h0, run_cmd});
        @(posedge clk);
        cmd <= 3'h4;
        motor_current <= 16'h7 + 16'($random(seed) & 1);
        for (i = 0; i < 2000 && remaining_heat_readout > 7'h3c; i++) @(posedge clk);
        // Zero current freezes the percent while the accumulator drains
        motor_current <= 16'h0;
        settle(12);
        @(posedge clk);
        at_speed <= 1'b1;
        heat = remaining_heat_readout;
        rd(8'h1c, 32'((7'h64 - heat) / 7'h03));
        motor_current <= 16'h8;
        for (i = 0; i < 2000 && overload_trip !== 1'b1; i++) @(posedge clk);
        settle(1);
        cmp("trip", 32'h1, {31'h0, overload_trip});
        cmp("run_cmd", 32'h0, {31'h0, run_cmd});
        cmp("led", 32'h1, {31'h0, overload_led});
        rd(8'h18, 32'h0);
        cmd <= 3'h0;
        motor_current <= 16'h0;
        key(3'h4);
        settle(3);
        cmp("trip", 32'h1, {31'h0, overload_trip});
        for (i = 0; i < 40000 && overload_led !== 1'b0; i++) @(posedge clk);
        settle(1);
        cmp("led", 32'h0, {31'h0, overload_led});
        cmp("trip", 32'h1, {31'h0, overload_trip});
        key(3'h4);
        settle(2);
        cmp("trip", 32'h0, {31'h0, overload_trip});
        wr(8'h10, 32'h1);
        motor_current <= 16'h7;
        for (i = 0; i < 2000 && overload_trip !== 1'b1; i++) @(posedge clk);
        settle(1);
        cmp("trip", 32'h1, {31'h0, overload_trip});
        motor_current <= 16'h0;
        for (i = 0; i < 45000 && overload_trip !== 1'b0; i++) @(posedge clk);
        settle(1);
        cmp("trip", 32'h0, {31'h0, overload_trip});
        key(3'h3);
        settle(2);
        cmp("run_cmd", 32'h1, {31'h0, run_cmd});
        wr(8'h10, 32'h2);
        motor_current <= 16'h7;
        settle(600);
        cmp("trip", 32'h0, {31'h0, overload_trip});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle(8);
        cmp("readout", 32'h0, {25'h0, remaining_heat_readout});
        complete_run();
    end
endmodule : motor_thermal_overload_tb
